// [rtl/rfc_pkg.sv]
package rfc_pkg;

	////////////////////////////////////////////////////////////////
	// timing, in the units printed, and derived cycle counts
	localparam int unsigned CLK_PERIOD_PS = 50000;
	localparam int unsigned CYC_PER_US = 1000000 / CLK_PERIOD_PS;
	localparam int unsigned CYC_PER_MS = 1000 * CYC_PER_US;
	localparam int unsigned RES_BASIC_PS = 250;
	localparam int unsigned RES_HI_PS = 50;
	localparam longint unsigned PS_PER_S = 64'h000000e8d4a51000;
	localparam int unsigned TO_STEP_MS = 100;
	localparam int unsigned TO_SHORT_MS = 64;
	localparam int unsigned TO_STEP_CYC = TO_STEP_MS * CYC_PER_MS;
	localparam int unsigned TO_SHORT_CYC = TO_SHORT_MS * CYC_PER_MS;
	localparam int unsigned OVH_AUTO_US = 200000;
	localparam int unsigned OVH_MAN_US = 1000;
	localparam int unsigned OVH_REM_US = 120;
	localparam int unsigned OVH_AUTO_CYC = OVH_AUTO_US * CYC_PER_US;
	localparam int unsigned OVH_MAN_CYC = OVH_MAN_US * CYC_PER_US;
	localparam int unsigned OVH_REM_CYC = OVH_REM_US * CYC_PER_US;
	localparam logic [6:0] DIV_LAST = 7'h3f;

	////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {S_IDLE, S_ARM, S_GATE, S_DIV, S_STAT, S_SCALE, S_DONE, S_OVH}
		rfc_state_type;
	typedef enum logic [1:0] {ST_OFF, ST_MEAN, ST_MAX, ST_MIN} rfc_stat_type;

	typedef struct packed {
		logic run;
		logic single;
		logic [9:0] presc;
		logic [31:0] measCyc;
		logic [7:0] toSel;
		logic toShort;
		logic autoTrig;
		logic remote;
		rfc_stat_type statMode;
		logic [15:0] statN;
		logic scaleEn;
		logic signed [31:0] kConst;
		logic signed [31:0] lConst;
		logic signed [31:0] mConst;
	} rfc_cfg_type;

	typedef struct packed {
		rfc_state_type st;
		rfc_state_type ret;
		logic [47:0] tg;
		logic [31:0] win;
		logic winDone;
		logic [31:0] cyc;
		logic [31:0] to;
		logic noSig;
		logic [63:0] dq;
		logic [64:0] dr;
		logic [63:0] dd;
		logic [6:0] dn;
		logic neg;
		logic [15:0] sIdx;
		logic [63:0] sum;
		logic [31:0] sMax;
		logic [31:0] sMin;
		logic signed [31:0] res;
		logic resV;
		logic gate;
		logic busy;
		logic [31:0] ovh;
	} rfc_reg_type;

endpackage : rfc_pkg

// [rtl/rfc_core.sv]
`timescale 1ns/1ps

module rfc_core #(
	parameter bit HI_RES = 1'b0,
	parameter int unsigned TO_STEP = rfc_pkg::TO_STEP_CYC,
	parameter int unsigned TO_SHORT = rfc_pkg::TO_SHORT_CYC,
	parameter int unsigned OVH_AUTO = rfc_pkg::OVH_AUTO_CYC,
	parameter int unsigned OVH_MAN = rfc_pkg::OVH_MAN_CYC
) (
	input logic clk,
	input logic sys_rst,
	input logic trigger,
	input rfc_pkg::rfc_cfg_type cfg,
	output logic signed [31:0] result,
	output logic resultValid,
	output logic noSignal,
	output logic gateOpen,
	output logic busy
);

	////////////////////////////////////////////////////////////////
	localparam int unsigned RES_PS = HI_RES ? rfc_pkg::RES_HI_PS : rfc_pkg::RES_BASIC_PS;
	localparam logic [47:0] TICKS = 48'(rfc_pkg::CLK_PERIOD_PS / RES_PS);
	localparam logic [63:0] CPS = 64'(rfc_pkg::PS_PER_S / RES_PS);

	rfc_pkg::rfc_reg_type rg_ff;
	rfc_pkg::rfc_reg_type nxt_rg;
	logic [64:0] trial;
	logic [31:0] toLim;
	logic [31:0] ovhLim;
	logic inMeas;
	logic abort;
	logic closeNow;
	logic [31:0] x;
	logic [63:0] sumN;
	logic [31:0] maxN;
	logic [31:0] minN;
	logic [15:0] idxN;
	logic signed [63:0] num;
	logic [63:0] numAbs;
	logic [31:0] mAbs;

	function automatic rfc_pkg::rfc_reg_type divGo(input rfc_pkg::rfc_reg_type s,
		input logic [63:0] a, input logic [63:0] b, input rfc_pkg::rfc_state_type ret);
		rfc_pkg::rfc_reg_type t;
		t = s;
		t.dq = a;
		t.dd = b;
		t.dr = '0;
		t.dn = '0;
		t.ret = ret;
		t.st = rfc_pkg::S_DIV;
		return t;
	endfunction : divGo

	// a new interval starts here; the timeout count restarts with it
	function automatic rfc_pkg::rfc_reg_type armGo(input rfc_pkg::rfc_reg_type s);
		rfc_pkg::rfc_reg_type t;
		t = s;
		t.st = rfc_pkg::S_ARM;
		t.busy = 1'b1;
		t.win = '0;
		t.winDone = 1'b0;
		t.to = '0;
		t.gate = 1'b0;
		return t;
	endfunction : armGo

	////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_rg = rg_ff;
		nxt_rg.resV = 1'b0;
		trial = {rg_ff.dr[63:0], rg_ff.dq[63]};
		// zero toSel means the timeout is off, unless toShort picks the short timeout in HI_RES
		toLim = (HI_RES && cfg.toShort) ? TO_SHORT : 32'(cfg.toSel) * TO_STEP;
		ovhLim = cfg.remote ? rfc_pkg::OVH_REM_CYC : cfg.autoTrig ? OVH_AUTO : OVH_MAN;
		inMeas = (rg_ff.st == rfc_pkg::S_ARM) || (rg_ff.st == rfc_pkg::S_GATE);
		abort = inMeas && (toLim != 32'h0) && !trigger && (rg_ff.to + 32'h1 >= toLim);
		closeNow = trigger && (cfg.single || rg_ff.winDone);
		x = rg_ff.dq[31:0];
		idxN = rg_ff.sIdx + 16'h1;
		sumN = (rg_ff.sIdx == 16'h0) ? 64'(x) : rg_ff.sum + 64'(x);
		maxN = (rg_ff.sIdx == 16'h0 || x > rg_ff.sMax) ? x : rg_ff.sMax;
		minN = (rg_ff.sIdx == 16'h0 || x < rg_ff.sMin) ? x : rg_ff.sMin;
		num = $signed({{32{cfg.kConst[31]}}, cfg.kConst}) * $signed({32'h0, x})
			+ $signed({{32{cfg.lConst[31]}}, cfg.lConst});
		numAbs = num[63] ? -num : num;
		mAbs = cfg.mConst[31] ? -cfg.mConst : cfg.mConst;

		if (inMeas) begin
			nxt_rg.win = rg_ff.win + 32'h1;
			if (rg_ff.win + 32'h1 >= cfg.measCyc) begin
				nxt_rg.winDone = 1'b1;
			end
			nxt_rg.to = trigger ? 32'h0 : rg_ff.to + 32'h1;
		end

		case (rg_ff.st)
			rfc_pkg::S_IDLE: begin
				nxt_rg.sIdx = '0;
				if (cfg.run) begin
					// build on the cleared copy so no statistics index survives a stop
					nxt_rg = armGo(nxt_rg);
				end
			end
			rfc_pkg::S_ARM: begin
				if (abort) begin
					// previous result stays untouched
					nxt_rg.noSig = 1'b1;
					nxt_rg.st = rfc_pkg::S_OVH;
					nxt_rg.ovh = '0;
				end else if (trigger) begin
					nxt_rg.gate = 1'b1;
					nxt_rg.st = rfc_pkg::S_GATE;
					nxt_rg.cyc = '0;
					nxt_rg.tg = '0;
				end
			end
			rfc_pkg::S_GATE: begin
				nxt_rg.tg = rg_ff.tg + TICKS;
				if (abort) begin
					nxt_rg.gate = 1'b0;
					nxt_rg.noSig = 1'b1;
					nxt_rg.st = rfc_pkg::S_OVH;
					nxt_rg.ovh = '0;
				end else if (trigger) begin
					nxt_rg.cyc = rg_ff.cyc + 32'h1;
					if (closeNow) begin
						// trigger-aligned close keeps an exact cycle count
						nxt_rg = divGo(nxt_rg, 64'(rg_ff.cyc + 32'h1) * 64'(cfg.presc) * CPS,
							64'(rg_ff.tg + TICKS), rfc_pkg::S_STAT);
						nxt_rg.gate = 1'b0;
					end
				end
			end
			rfc_pkg::S_DIV: begin
				if (trial >= {1'b0, rg_ff.dd}) begin
					nxt_rg.dr = trial - {1'b0, rg_ff.dd};
					nxt_rg.dq = {rg_ff.dq[62:0], 1'b1};
				end else begin
					nxt_rg.dr = trial;
					nxt_rg.dq = {rg_ff.dq[62:0], 1'b0};
				end
				nxt_rg.dn = rg_ff.dn + 7'h1;
				if (rg_ff.dn == rfc_pkg::DIV_LAST) begin
					nxt_rg.st = rg_ff.ret;
				end
			end
			rfc_pkg::S_STAT: begin
				nxt_rg.noSig = 1'b0;
				if (cfg.statMode == rfc_pkg::ST_OFF) begin
					nxt_rg.st = rfc_pkg::S_SCALE;
				end else begin
					nxt_rg.sum = sumN;
					nxt_rg.sMax = maxN;
					nxt_rg.sMin = minN;
					nxt_rg.sIdx = idxN;
					if (idxN >= cfg.statN) begin
						nxt_rg.sIdx = '0;
						case (cfg.statMode)
							rfc_pkg::ST_MEAN: nxt_rg = divGo(nxt_rg, sumN, 64'(cfg.statN),
								rfc_pkg::S_SCALE);
							rfc_pkg::ST_MAX: begin
								nxt_rg.dq = 64'(maxN);
								nxt_rg.st = rfc_pkg::S_SCALE;
							end
							default: begin
								nxt_rg.dq = 64'(minN);
								nxt_rg.st = rfc_pkg::S_SCALE;
							end
						endcase
					end else begin
						nxt_rg.st = rfc_pkg::S_OVH;
						nxt_rg.ovh = '0;
					end
				end
			end
			rfc_pkg::S_SCALE: begin
				nxt_rg.neg = 1'b0;
				nxt_rg.st = rfc_pkg::S_DONE;
				if (cfg.scaleEn) begin
					nxt_rg = divGo(rg_ff, numAbs, 64'(mAbs), rfc_pkg::S_DONE);
					nxt_rg.neg = num[63] ^ cfg.mConst[31];
				end
			end
			rfc_pkg::S_DONE: begin
				nxt_rg.res = rg_ff.neg ? -rg_ff.dq[31:0] : rg_ff.dq[31:0];
				nxt_rg.resV = 1'b1;
				nxt_rg.st = rfc_pkg::S_OVH;
				nxt_rg.ovh = '0;
			end
			rfc_pkg::S_OVH: begin
				nxt_rg.ovh = rg_ff.ovh + 32'h1;
				if (rg_ff.ovh + 32'h1 >= ovhLim) begin
					if (cfg.run) begin
						nxt_rg = armGo(nxt_rg);
					end else begin
						nxt_rg.st = rfc_pkg::S_IDLE;
						nxt_rg.busy = 1'b0;
					end
				end
			end
			default: begin
				nxt_rg.st = rfc_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rg_ff <= '0;
		end else begin
			rg_ff <= nxt_rg;
		end
	end

	assign result = rg_ff.res;
	assign resultValid = rg_ff.resV;
	assign noSignal = rg_ff.noSig;
	assign gateOpen = rg_ff.gate;
	assign busy = rg_ff.busy;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence trigInGate;
		rg_ff.gate && trigger && !abort;
	endsequence

	sequence lastTrig;
		trigInGate ##0 closeNow;
	endsequence

	open_on_trig_a: assert property ($rose(rg_ff.gate) |-> $past(trigger)
		&& $past(rg_ff.st) == rfc_pkg::S_ARM)
		else $error("gate opened without a trigger");

	arm_waits_a: assert property (rg_ff.st == rfc_pkg::S_ARM && !trigger |=> !rg_ff.gate)
		else $error("gate opened early");

	gate_close_a: assert property (lastTrig |=> !rg_ff.gate && rg_ff.st == rfc_pkg::S_DIV)
		else $error("gate did not close on trigger");

	gate_hold_a: assert property (trigInGate ##0 !closeNow |=> rg_ff.gate)
		else $error("gate closed before interval end");

	cycle_count_a: assert property (trigInGate |=> rg_ff.cyc == $past(rg_ff.cyc) + 32'h1)
		else $error("cycle count not advanced");

	time_count_a: assert property (rg_ff.gate && !abort
		|=> rg_ff.tg == $past(rg_ff.tg) + TICKS)
		else $error("gate time not advanced");

	hold_result_a: assert property ($rose(rg_ff.noSig) |-> $stable(rg_ff.res))
		else $error("result changed on lost signal");

	timeout_a: assert property (abort |=> rg_ff.noSig && !rg_ff.gate
		&& rg_ff.st == rfc_pkg::S_OVH)
		else $error("timeout not taken");

	to_restart_a: assert property (inMeas && trigger |=> rg_ff.to == 32'h0)
		else $error("timeout count not cleared");

	valid_pulse_a: assert property (rg_ff.resV |-> !rg_ff.noSig
		&& rg_ff.st == rfc_pkg::S_OVH ##1 !rg_ff.resV)
		else $error("bad result pulse");

	start_arms_a: assert property (rg_ff.st == rfc_pkg::S_IDLE && cfg.run
		|=> rg_ff.st == rfc_pkg::S_ARM && rg_ff.busy && rg_ff.to == 32'h0)
		else $error("start did not arm");

	timeout_wait_a: assert property (inMeas && !trigger
		&& (toLim == 32'h0 || rg_ff.to + 32'h1 < toLim) |=> inMeas)
		else $error("measurement left without cause");

	one_period_a: assert property (trigInGate ##0 cfg.single
		|=> !rg_ff.gate)
		else $error("single aperture not closed");

	div_steps_a: assert property (rg_ff.st == rfc_pkg::S_DIV && rg_ff.dn != rfc_pkg::DIV_LAST
		|=> rg_ff.st == rfc_pkg::S_DIV && rg_ff.dn == $past(rg_ff.dn) + 7'h1)
		else $error("divide cut short");

	stat_gather_a: assert property (rg_ff.st == rfc_pkg::S_STAT
		&& cfg.statMode != rfc_pkg::ST_OFF && idxN < cfg.statN
		|=> rg_ff.st == rfc_pkg::S_OVH && !rg_ff.resV)
		else $error("statistics reported early");

	ovh_wait_a: assert property (rg_ff.st == rfc_pkg::S_OVH
		&& rg_ff.ovh + 32'h1 < ovhLim |=> rg_ff.st == rfc_pkg::S_OVH)
		else $error("overhead ended early");

endmodule : rfc_core

// [test/rfc_trig_src.sv]
`timescale 1ns/1ps

module rfc_trig_src #(
	parameter int PERIOD = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic en,
	output logic trigger
);
	int cnt = 0;
	logic enNow;
	// one-cycle pulse every PERIOD clocks while enabled, silent otherwise
	// enable and reset are read at the edge, before the bench moves them
	always @(posedge clk) begin
		enNow = en && !sys_rst;
		#1;
		if (!enNow) begin
			cnt = 0;
			trigger = 1'b0;
		end else begin
			trigger = (cnt == 0);
			cnt = (cnt == PERIOD - 1) ? 0 : cnt + 1;
		end
	end
endmodule : rfc_trig_src

// [test/testbench.sv]
`timescale 1ns/1ps

module testbench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic trigEn = 1'b0;
	logic trigger;
	rfc_pkg::rfc_cfg_type cfg;
	logic signed [31:0] result;
	logic resultValid, noSignal, gateOpen, busy;
	int err_total = 0;
	int comparisons = 0;
	int ovhExp = 20;

	rfc_core #(.TO_STEP(50), .TO_SHORT(32), .OVH_AUTO(20), .OVH_MAN(10)) rfc_core_inst (
		.clk(clk), .sys_rst(sys_rst), .trigger(trigger), .cfg(cfg), .result(result),
		.resultValid(resultValid), .noSignal(noSignal), .gateOpen(gateOpen), .busy(busy));
	rfc_trig_src #(.PERIOD(5)) rfc_trig_src_inst (
		.clk(clk), .sys_rst(sys_rst), .en(trigEn), .trigger(trigger));

	initial forever #25 clk = ~clk;

	////////////////////////////////////////////////////////////////
	task automatic chk_val(input logic signed [31:0] got, input logic signed [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t result %0d expected %0d", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// run one measurement; 5-clock trigger period gives 2e7/5 Hz per unit of prescale
	task automatic measure(input logic signed [31:0] exp);
		logic ok;
		int ovhCnt;
		ok = 1'b0;
		ovhCnt = 0;
		cfg.run = 1'b1;
		for (int i = 0; i < 2000 && !ok; i++) begin
			step(1);
			ok = (resultValid === 1'b1);
		end
		chk_bit(ok, 1'b1);
		chk_val(result, exp);
		cfg.run = 1'b0;
		while (ovhCnt < 3000 && busy !== 1'b0) begin
			step(1);
			ovhCnt++;
		end
		chk_bit(busy, 1'b0);
		chk_cnt(ovhCnt, ovhExp);
	endtask : measure

	////////////////////////////////////////////////////////////////
	task automatic sc_gate;
		trigEn = 1'b0;
		cfg.run = 1'b1;
		step(120);
		chk_bit(gateOpen, 1'b0);
		chk_bit(noSignal, 1'b0);
		trigEn = 1'b1;
		for (int i = 0; i < 20 && gateOpen !== 1'b1; i++) step(1);
		chk_bit(gateOpen, 1'b1);
		measure(32'sd4000000);
	endtask : sc_gate

	task automatic sc_presc;
		cfg.presc = 10'h004;
		measure(32'sd16000000);
		cfg.single = 1'b1;
		measure(32'sd16000000);
		cfg.single = 1'b0;
		cfg.presc = 10'h001;
	endtask : sc_presc

	task automatic sc_timeout;
		cfg.toSel = 8'h01;
		trigEn = 1'b0;
		cfg.run = 1'b1;
		for (int i = 0; i < 200 && noSignal !== 1'b1; i++) step(1);
		chk_bit(noSignal, 1'b1);
		chk_bit(gateOpen, 1'b0);
		chk_val(result, 32'sd16000000);
		trigEn = 1'b1;
		measure(32'sd4000000);
		chk_bit(noSignal, 1'b0);
		cfg.toSel = 8'h00;
	endtask : sc_timeout

	task automatic sc_stats;
		rfc_pkg::rfc_stat_type modes [3];
		modes = '{rfc_pkg::ST_MEAN, rfc_pkg::ST_MAX, rfc_pkg::ST_MIN};
		cfg.statN = 16'h0002;
		foreach (modes[i]) begin
			cfg.statMode = modes[i];
			measure(32'sd4000000);
		end
		cfg.statMode = rfc_pkg::ST_OFF;
	endtask : sc_stats

	task automatic sc_scale;
		cfg.scaleEn = 1'b1;
		cfg.kConst = 32'sd2;
		cfg.lConst = -32'sd1000000;
		cfg.mConst = 32'sd2;
		measure(32'sd3500000);
		cfg.scaleEn = 1'b0;
	endtask : sc_scale

	task automatic sc_ovh;
		cfg.autoTrig = 1'b0;
		ovhExp = 10;
		measure(32'sd4000000);
		cfg.remote = 1'b1;
		ovhExp = rfc_pkg::OVH_REM_CYC;
		measure(32'sd4000000);
		cfg.remote = 1'b0;
		cfg.autoTrig = 1'b1;
		ovhExp = 20;
	endtask : sc_ovh

	task automatic complete_run;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	initial begin
		#1000000;
		err_total++;
		complete_run;
	end

	initial begin
		cfg = '0;
		cfg.presc = 10'h001;
		cfg.measCyc = 32'h00000014;
		cfg.autoTrig = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		step(2);
		sc_gate;
		sc_presc;
		sc_timeout;
		sc_stats;
		sc_scale;
		sc_ovh;
		complete_run;
	end
endmodule : testbench
